// ### design/fiber_amp_defines.svh
// offsets, reset values and timing counts shared by both ends of the fiber amplifier link
`ifndef FIBER_AMP_DEFINES_SVH
`define FIBER_AMP_DEFINES_SVH
`define REG_AW            4
`define REG_DW            16
`define LEVEL_W           12
// node register indices
`define NODE_STATION      4'h0
`define NODE_THRESHOLD    4'h1
`define NODE_HYSTERESIS   4'h2
`define NODE_ALARM_HI     4'h3
`define NODE_ALARM_LO     4'h4
`define NODE_LEVEL_MODE   4'h5
`define NODE_TEACH        4'h6
`define NODE_STATUS       4'h7
`define NODE_REF_ON       4'h8
`define NODE_REF_OFF      4'h9
`define NODE_LEVEL        4'ha
// host register indices
`define HOST_CTRL         4'h0
`define HOST_UNITS        4'h1
`define HOST_SELECT       4'h2
`define HOST_INPUT        4'h3
`define HOST_STATUS       4'h4
// reset values
`define STATION_UNSET     8'hff
`define THRESHOLD_RESET   12'h032
`define HYSTERESIS_RESET  12'h005
`define ALARM_RESET       12'h000
`define UNITS_MAX         8'h80
// teaching ratios in percent
`define PCT_THRESHOLD     7'd50
`define PCT_HYSTERESIS    7'd5
`define PCT_ALARM_HI      7'd80
`define PCT_ALARM_LO      7'd20
// block layout
`define BLOCK_POINTS      32
// link timing in CORE_CLK cycles
`define SLOT_CYCLES       8
`define SAMPLE_CYCLE      3'd6
`define DRIVE_CYCLES      3'd4
`endif

// ### design/fiber_amp_pkg.sv
// state types of the fiber amplifier node and of the line master
package fiber_amp_pkg;

    typedef enum logic [0:0] {LEVEL_RAW, LEVEL_PERCENT} level_mode_type;

    typedef struct packed {
        logic [7:0]     station;
        logic [11:0]    threshold;
        logic [11:0]    hysteresis;
        logic [11:0]    alarm_hi;
        logic [11:0]    alarm_lo;
        level_mode_type level_mode;
        logic [11:0]    ref_on;
        logic [11:0]    ref_off;
        logic           on_valid;
        logic           off_valid;
        logic           calc_pend;
        logic           detect;
        logic           alm_hi;
        logic           alm_lo;
        logic [15:0]    rdata;
        logic [1:0]     pos_sync;
        logic [1:0]     neg_sync;
        logic [7:0]     slot;
        logic           slot_valid;
        logic [2:0]     drive_cnt;
        logic           neg_oe_n;
    } node_state_type;

    typedef struct packed {
        logic           run;
        logic [7:0]     units;
        logic [7:0]     select;
        logic [255:0]   inputs;
        logic [7:0]     slot;
        logic [2:0]     cyc;
        logic           pos;
        logic           neg_oe_n;
        logic [1:0]     neg_sync;
        logic [15:0]    frames;
        logic [15:0]    rdata;
    } host_state_type;

endpackage

// ### design/fiber_link_if.sv
// two-wire transmission line between the line master and one amplifier node
`timescale 1ns/1ps
interface fiber_link_if;
    logic line_pos;
    logic host_neg_o;
    logic host_neg_oe_n;
    logic node_neg_o;
    logic node_neg_oe_n;
    logic line_neg;

    // wired-and: a released pin floats high
    assign line_neg = (host_neg_oe_n | host_neg_o) & (node_neg_oe_n | node_neg_o);

    modport host (output line_pos, output host_neg_o, output host_neg_oe_n, input line_neg);
    modport node (input line_pos, input line_neg, output node_neg_o, output node_neg_oe_n);
endinterface

// ### design/fiber_amp_node.sv
// amplifier node: station address, teaching, detection and slot answer on the line
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "fiber_amp_defines.svh"

module fiber_amp_node (
    input  wire logic                  CORE_CLK,     // system clock, 20 MHz
    input  wire logic                  RESET_N,      // asynchronous reset, active low
    fiber_link_if.node                 LINK,         // transmission line
    input  wire logic [`LEVEL_W-1:0]   LIGHT_LEVEL,  // light level sample, same clock
    input  wire logic [4:0]            EXP_INDEX,    // 0 master amplifier, 1..31 expansion
    input  wire logic [`REG_AW-1:0]    REG_ADDR,     // register index
    input  wire logic [`REG_DW-1:0]    REG_WDATA,    // write data
    input  wire logic                  REG_WE,       // write strobe
    input  wire logic                  REG_RE,       // read strobe
    output logic [`REG_DW-1:0]         REG_RDATA,    // read data, cycle after strobe
    output logic                       DETECT,       // detection status
    output logic                       ALARM_HI,     // level above upper alarm limit
    output logic                       ALARM_LO      // level below lower alarm limit
);
    import fiber_amp_pkg::*;

    node_state_type state;
    node_state_type next_state;

    // truncating percentage of a span
    function automatic logic [11:0] pct(input logic [11:0] span, input logic [6:0] p);
        logic [18:0] prod;
        logic [18:0] quot;
        prod = {7'h00, span} * {12'h000, p};
        quot = prod / 19'h00064;
        return quot[11:0];
    endfunction

    logic [11:0] span;
    logic [12:0] own_slot;
    logic [12:0] release_sum;
    logic        my_slot;

    always_comb begin
        next_state = state;
        span = (state.ref_on >= state.ref_off) ? state.ref_on - state.ref_off
                                               : state.ref_off - state.ref_on;
        own_slot = {5'h00, state.station} + {8'h00, EXP_INDEX};
        release_sum = {1'b0, LIGHT_LEVEL} + {1'b0, state.hysteresis};
        my_slot = 1'b0;

        // pin inputs, two flops each
        next_state.pos_sync = {state.pos_sync[0], LINK.line_pos};
        next_state.neg_sync = {state.neg_sync[0], LINK.line_neg};

        // slot tracking: a pulse with the negative line held low marks slot 0
        if (state.pos_sync[1]) begin
            if (!state.neg_sync[1]) begin
                next_state.slot = 8'h00;
                next_state.slot_valid = 1'b1;
            end else begin
                next_state.slot = state.slot + 8'h01;
            end
        end

        // answer in own slot only once assigned; a station plus expansion index past 254 stays silent
        if (state.pos_sync[1] && next_state.slot_valid && state.station != `STATION_UNSET) begin
            my_slot = (own_slot == {5'h00, next_state.slot}) && (own_slot < 13'h00ff);
        end
        // drive only part of the slot so the line is free before the next pulse
        if (my_slot && state.detect) begin
            next_state.drive_cnt = `DRIVE_CYCLES;
        end else if (state.drive_cnt != 3'h0) begin
            next_state.drive_cnt = state.drive_cnt - 3'h1;
        end
        next_state.neg_oe_n = (next_state.drive_cnt == 3'h0);

        // detection with hysteresis
        if (!state.detect) begin
            if (LIGHT_LEVEL >= state.threshold) begin
                next_state.detect = 1'b1;
            end
        end else if (release_sum < {1'b0, state.threshold}) begin
            next_state.detect = 1'b0;
        end
        next_state.alm_hi = LIGHT_LEVEL > state.alarm_hi;
        next_state.alm_lo = LIGHT_LEVEL < state.alarm_lo;

        // pending calculation lasts one cycle; a capture in that cycle sets it again
        next_state.calc_pend = 1'b0;

        // register writes
        if (REG_WE) begin
            unique case (REG_ADDR)
                `NODE_STATION: begin
                    next_state.station = REG_WDATA[7:0];
                end
                `NODE_THRESHOLD: begin
                    next_state.threshold = REG_WDATA[11:0];
                end
                `NODE_HYSTERESIS: begin
                    next_state.hysteresis = REG_WDATA[11:0];
                end
                `NODE_ALARM_HI: begin
                    next_state.alarm_hi = REG_WDATA[11:0];
                end
                `NODE_ALARM_LO: begin
                    next_state.alarm_lo = REG_WDATA[11:0];
                end
                `NODE_LEVEL_MODE: begin
                    next_state.level_mode = REG_WDATA[0] ? LEVEL_PERCENT : LEVEL_RAW;
                end
                `NODE_TEACH: begin
                    if (REG_WDATA[0]) begin
                        next_state.ref_on = LIGHT_LEVEL;
                        next_state.on_valid = 1'b1;
                        next_state.calc_pend = 1'b1;
                    end
                    if (REG_WDATA[1]) begin
                        next_state.ref_off = LIGHT_LEVEL;
                        next_state.off_valid = 1'b1;
                        next_state.calc_pend = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // automatic teaching one cycle after a capture, in raw level mode only, once both references exist
        if (state.calc_pend) begin
            if (state.on_valid && state.off_valid && state.level_mode == LEVEL_RAW) begin
                next_state.threshold = pct(span, `PCT_THRESHOLD);
                next_state.hysteresis = pct(span, `PCT_HYSTERESIS);
                next_state.alarm_hi = pct(span, `PCT_ALARM_HI);
                next_state.alarm_lo = pct(span, `PCT_ALARM_LO);
            end
        end

        // register reads; unmapped indices read zero
        next_state.rdata = 16'h0000;
        if (REG_RE) begin
            unique case (REG_ADDR)
                `NODE_STATION: begin
                    next_state.rdata = {8'h00, state.station};
                end
                `NODE_THRESHOLD: begin
                    next_state.rdata = {4'h0, state.threshold};
                end
                `NODE_HYSTERESIS: begin
                    next_state.rdata = {4'h0, state.hysteresis};
                end
                `NODE_ALARM_HI: begin
                    next_state.rdata = {4'h0, state.alarm_hi};
                end
                `NODE_ALARM_LO: begin
                    next_state.rdata = {4'h0, state.alarm_lo};
                end
                `NODE_LEVEL_MODE: begin
                    next_state.rdata = {15'h0000, state.level_mode == LEVEL_PERCENT};
                end
                `NODE_STATUS: begin
                    // both valid bits let software check before choosing percentage mode
                    next_state.rdata = {9'h000, state.slot_valid, state.calc_pend,
                                        state.off_valid, state.on_valid,
                                        state.alm_lo, state.alm_hi, state.detect};
                end
                `NODE_REF_ON: begin
                    next_state.rdata = {4'h0, state.ref_on};
                end
                `NODE_REF_OFF: begin
                    next_state.rdata = {4'h0, state.ref_off};
                end
                `NODE_LEVEL: begin
                    next_state.rdata = {4'h0, LIGHT_LEVEL};
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state <= '0;
            state.station <= `STATION_UNSET;
            state.threshold <= `THRESHOLD_RESET;
            state.hysteresis <= `HYSTERESIS_RESET;
            state.alarm_hi <= `ALARM_RESET;
            state.alarm_lo <= `ALARM_RESET;
            state.level_mode <= LEVEL_RAW;
            state.pos_sync <= 2'b00;
            state.neg_sync <= 2'b11;
            state.neg_oe_n <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign LINK.node_neg_o = 1'b0;
    assign LINK.node_neg_oe_n = state.neg_oe_n;
    assign REG_RDATA = state.rdata;
    assign DETECT = state.detect;
    assign ALARM_HI = state.alm_hi;
    assign ALARM_LO = state.alm_lo;

endmodule

// ### design/fiber_line_master.sv
// line master: frame and slot pulses, collection of station inputs, control registers
`timescale 1ns/1ps
`include "fiber_amp_defines.svh"

module fiber_line_master (
    input  wire logic                  CORE_CLK,   // system clock, 20 MHz
    input  wire logic                  RESET_N,    // asynchronous reset, active low
    fiber_link_if.host                 LINK,       // transmission line
    input  wire logic [`REG_AW-1:0]    REG_ADDR,   // register index
    input  wire logic [`REG_DW-1:0]    REG_WDATA,  // write data
    input  wire logic                  REG_WE,     // write strobe
    input  wire logic                  REG_RE,     // read strobe
    output logic [`REG_DW-1:0]         REG_RDATA,  // read data, cycle after strobe
    output logic                       RUNNING     // transmission active
);
    import fiber_amp_pkg::*;

    host_state_type state;
    host_state_type next_state;

    always_comb begin
        next_state = state;
        next_state.neg_sync = {state.neg_sync[0], LINK.line_neg};

        // stopped line: no pulses, and the next start begins at slot 0
        if (!state.run) begin
            next_state.cyc = 3'(`SLOT_CYCLES - 1);
            next_state.slot = state.units - 8'h01;
        end else begin
            next_state.cyc = state.cyc + 3'h1;
            if (state.cyc == 3'(`SLOT_CYCLES - 1)) begin
                if (state.slot >= state.units - 8'h01) begin
                    next_state.slot = 8'h00;
                    next_state.frames = state.frames + 16'h0001;
                end else begin
                    next_state.slot = state.slot + 8'h01;
                end
            end
            // an answering node pulls the line low
            if (state.cyc == `SAMPLE_CYCLE) begin
                next_state.inputs[state.slot] = ~state.neg_sync[1];
            end
        end
        next_state.pos = state.run && next_state.cyc == 3'h0;
        next_state.neg_oe_n = !(next_state.pos && next_state.slot == 8'h00);

        if (REG_WE) begin
            unique case (REG_ADDR)
                `HOST_CTRL: begin
                    next_state.run = REG_WDATA[0];
                end
                `HOST_UNITS: begin
                    if (REG_WDATA > {8'h00, `UNITS_MAX}) begin
                        next_state.units = `UNITS_MAX;
                    end else if (REG_WDATA == 16'h0000) begin
                        next_state.units = 8'h01;
                    end else begin
                        next_state.units = REG_WDATA[7:0];
                    end
                end
                `HOST_SELECT: begin
                    next_state.select = REG_WDATA[7:0];
                end
                default: begin
                end
            endcase
        end

        next_state.rdata = 16'h0000;
        if (REG_RE) begin
            unique case (REG_ADDR)
                `HOST_CTRL: begin
                    next_state.rdata = {15'h0000, state.run};
                end
                `HOST_UNITS: begin
                    next_state.rdata = {8'h00, state.units};
                end
                `HOST_SELECT: begin
                    next_state.rdata = {8'h00, state.select};
                end
                `HOST_INPUT: begin
                    next_state.rdata = {15'h0000, state.inputs[state.select]};
                end
                `HOST_STATUS: begin
                    next_state.rdata = state.frames;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state <= '0;
            state.units <= `UNITS_MAX;
            state.cyc <= 3'(`SLOT_CYCLES - 1);
            state.slot <= 8'h7f;
            state.neg_oe_n <= 1'b1;
            state.neg_sync <= 2'b11;
        end else begin
            state <= next_state;
        end
    end

    assign LINK.line_pos = state.pos;
    assign LINK.host_neg_o = 1'b0;
    assign LINK.host_neg_oe_n = state.neg_oe_n;
    assign REG_RDATA = state.rdata;
    assign RUNNING = state.run;

endmodule

// ### test/fiber_amp_checker.sv
// concurrent checks on the transmission line between line master and node
`timescale 1ns/1ps
module fiber_amp_checker (
    input wire logic CORE_CLK,      // system clock
    input wire logic RESET_N,       // asynchronous reset, active low
    input wire logic line_pos,      // slot pulse
    input wire logic host_neg_o,    // master pin value
    input wire logic host_neg_oe_n, // master pin enable, active low
    input wire logic node_neg_o,    // node pin value
    input wire logic node_neg_oe_n, // node pin enable, active low
    input wire logic line_neg       // resolved negative line
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESET_N);
    sequence drive_window;
        !node_neg_oe_n [*4] ##1 node_neg_oe_n;
    endsequence
    sequence slot_quiet;
        !line_pos [*7];
    endsequence
    pulse_spacing_a: assert property (line_pos |=> slot_quiet)
        else $error("slot pulse repeated inside a slot");
    frame_sync_a: assert property ($fell(host_neg_oe_n) |-> line_pos ##1 host_neg_oe_n)
        else $error("frame sync not a single cycle with the slot pulse");
    sync_with_pulse_a: assert property (!host_neg_oe_n |-> line_pos)
        else $error("master drives the line outside a slot pulse");
    answer_length_a: assert property ($fell(node_neg_oe_n) |-> drive_window)
        else $error("node answer is not four cycles long");
    answer_delay_a: assert property ($fell(node_neg_oe_n) |-> $past(line_pos, 3))
        else $error("node answer not three cycles after the slot pulse");
    answer_clear_a: assert property (!node_neg_oe_n |-> host_neg_oe_n && !line_pos)
        else $error("node answer overlaps a slot pulse");
    pins_pull_low_a: assert property (host_neg_o == 1'b0 && node_neg_o == 1'b0)
        else $error("a driver puts a high level on the negative line");
    wired_and_a: assert property (line_neg == (host_neg_oe_n & node_neg_oe_n))
        else $error("negative line level does not follow the enables");
endmodule

// ### test/tb_top.sv
// self-checking bench joining the line master and one amplifier node
`timescale 1ns/1ps
`include "fiber_amp_defines.svh"
module tb_top;
    logic                core_clk    = 1'b0;
    logic                reset_n     = 1'b0;
    logic [`LEVEL_W-1:0] light_level = 12'h000;
    logic [4:0]          exp_index   = 5'h00;
    logic [`REG_AW-1:0]  reg_addr    = 4'h0;
    logic [`REG_DW-1:0]  reg_wdata   = 16'h0000;
    logic                n_we = 1'b0, n_re = 1'b0, h_we = 1'b0, h_re = 1'b0;
    logic [`REG_DW-1:0]  n_rdata, h_rdata, rv;
    logic                detect, alarm_hi, alarm_lo, running;
    logic [11:0]         a, b;
    logic [11:0]         lv [5] = '{12'h1f4, 12'h1cc, 12'h1b8, 12'h320, 12'h064};
    logic [2:0]          ex [5] = '{3'h1, 3'h1, 3'h0, 3'h3, 3'h4};
    int                  num_errors = 0;
    int                  checked    = 0;

    always #25 core_clk = ~core_clk;

    fiber_link_if fiber_link_if_inst ();
    fiber_amp_node fiber_amp_node_inst (.CORE_CLK(core_clk), .RESET_N(reset_n), .LINK(fiber_link_if_inst),
        .LIGHT_LEVEL(light_level), .EXP_INDEX(exp_index), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WE(n_we), .REG_RE(n_re), .REG_RDATA(n_rdata), .DETECT(detect), .ALARM_HI(alarm_hi),
        .ALARM_LO(alarm_lo));
    fiber_line_master fiber_line_master_inst (.CORE_CLK(core_clk), .RESET_N(reset_n), .LINK(fiber_link_if_inst),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WE(h_we), .REG_RE(h_re), .REG_RDATA(h_rdata),
        .RUNNING(running));
    fiber_amp_checker fiber_amp_checker_inst (.CORE_CLK(core_clk), .RESET_N(reset_n),
        .line_pos(fiber_link_if_inst.line_pos), .host_neg_o(fiber_link_if_inst.host_neg_o),
        .host_neg_oe_n(fiber_link_if_inst.host_neg_oe_n), .node_neg_o(fiber_link_if_inst.node_neg_o),
        .node_neg_oe_n(fiber_link_if_inst.node_neg_oe_n), .line_neg(fiber_link_if_inst.line_neg));

    function automatic logic [15:0] pct(input logic [11:0] x, input logic [11:0] y, input logic [6:0] p);
        logic [31:0] d;
        d = (x > y) ? 32'(x - y) : 32'(y - x);
        return 16'((d * p) / 100);
    endfunction

    task automatic report_and_stop();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // entered just after a rising edge; strobe stands one cycle, then one idle cycle
    // so that a following call never raises a strobe in the step that lowered it
    task automatic wr(input logic m, input logic [3:0] ad, input logic [15:0] d);
        reg_addr <= ad;
        reg_wdata <= d;
        h_we <= m;
        n_we <= !m;
        @(posedge core_clk);
        h_we <= 1'b0;
        n_we <= 1'b0;
        @(posedge core_clk);
    endtask

    // read data stand only in the cycle after the strobe, sampled before that edge updates
    task automatic rd(input logic m, input logic [3:0] ad);
        reg_addr <= ad;
        h_re <= m;
        n_re <= !m;
        @(posedge core_clk);
        h_re <= 1'b0;
        n_re <= 1'b0;
        @(posedge core_clk);
        rv = m ? h_rdata : n_rdata;
    endtask

    task automatic rdc(input logic m, input logic [3:0] ad, input logic [15:0] exp);
        rd(m, ad);
        chk(rv, exp);
    endtask

    task automatic teach(input logic [11:0] x, input logic [11:0] y);
        light_level <= x;
        wr(1'b0, `NODE_TEACH, 16'h0001);
        light_level <= y;
        wr(1'b0, `NODE_TEACH, 16'h0002);
        rdc(1'b0, `NODE_REF_ON, {4'h0, x});
        rdc(1'b0, `NODE_REF_OFF, {4'h0, y});
    endtask

    task automatic check4(input logic [11:0] x, input logic [11:0] y);
        rdc(1'b0, `NODE_THRESHOLD, pct(x, y, `PCT_THRESHOLD));
        rdc(1'b0, `NODE_HYSTERESIS, pct(x, y, `PCT_HYSTERESIS));
        rdc(1'b0, `NODE_ALARM_HI, pct(x, y, `PCT_ALARM_HI));
        rdc(1'b0, `NODE_ALARM_LO, pct(x, y, `PCT_ALARM_LO));
    endtask

    // bounded poll: frames counter is the only completion sign on the link
    task automatic wait_frames(input logic [15:0] n);
        rv = 16'h0000;
        for (int i = 0; i < 200 && rv < n; i++) begin
            repeat (16) @(posedge core_clk);
            rd(1'b1, `HOST_STATUS);
        end
        chk({15'h0000, rv >= n}, 16'h0001);
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        report_and_stop();
    end

    initial begin
        void'($urandom(55));
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        rdc(1'b0, `NODE_STATION, 16'h00ff);
        rdc(1'b0, `NODE_THRESHOLD, 16'h0032);
        rdc(1'b0, `NODE_HYSTERESIS, 16'h0005);
        rdc(1'b0, `NODE_ALARM_HI, 16'h0000);
        rdc(1'b0, `NODE_LEVEL_MODE, 16'h0000);
        rdc(1'b0, `NODE_TEACH, 16'h0000);
        rdc(1'b0, 4'hb, 16'h0000);
        rdc(1'b1, `HOST_UNITS, 16'h0080);
        wr(1'b1, `HOST_UNITS, 16'h00c8);
        rdc(1'b1, `HOST_UNITS, 16'h0080);
        wr(1'b1, `HOST_UNITS, 16'h0000);
        rdc(1'b1, `HOST_UNITS, 16'h0001);
        repeat (4) begin
            a = 12'($urandom);
            b = 12'($urandom);
            teach(a, b);
            check4(a, b);
        end
        teach(12'h000, 12'h3d4);
        check4(12'h000, 12'h3d4);
        foreach (lv[i]) begin
            light_level <= lv[i];
            repeat (2) @(posedge core_clk);
            chk({13'h0000, alarm_lo, alarm_hi, detect}, {13'h0000, ex[i]});
        end
        // both references are already taught here
        wr(1'b0, `NODE_LEVEL_MODE, 16'h0001);
        rdc(1'b0, `NODE_LEVEL_MODE, 16'h0001);
        teach(12'h064, 12'hbb8);
        check4(12'h000, 12'h3d4);
        wr(1'b0, `NODE_LEVEL_MODE, 16'h0000);
        wr(1'b0, `NODE_THRESHOLD, 16'hffff);
        rdc(1'b0, `NODE_THRESHOLD, 16'h0fff);
        light_level <= 12'hfff;
        wr(1'b1, `HOST_UNITS, 16'h0028);
        wr(1'b1, `HOST_CTRL, 16'h0001);
        @(posedge core_clk);
        chk({15'h0000, running}, 16'h0001);
        chk({15'h0000, detect}, 16'h0001);
        wait_frames(16'h0002);
        wr(1'b1, `HOST_SELECT, 16'h0000);
        rdc(1'b1, `HOST_INPUT, 16'h0000);
        // line halted before the node position or address changes
        wr(1'b1, `HOST_CTRL, 16'h0000);
        // let the last slot and any node answer die out before the restart pulse
        repeat (16) @(posedge core_clk);
        exp_index <= 5'h1f;
        wr(1'b0, `NODE_STATION, 16'h0005);
        rdc(1'b0, `NODE_STATION, 16'h0005);
        wr(1'b1, `HOST_CTRL, 16'h0001);
        wait_frames(16'h0004);
        wr(1'b1, `HOST_SELECT, 16'h0024);
        rdc(1'b1, `HOST_INPUT, 16'h0001);
        wr(1'b1, `HOST_SELECT, 16'h0005);
        rdc(1'b1, `HOST_INPUT, 16'h0000);
        wr(1'b1, `HOST_SELECT, 16'h0025);
        rdc(1'b1, `HOST_INPUT, 16'h0000);
        report_and_stop();
    end
endmodule
